/* File: sim/flash_write_protect_decoder_tb_top.sv */
// flash_write_protect_decoder_tb_top: apb and command tests of the decoder
// assumes the host model drives commands and the bench drives apb alone
`timescale 1ns/1ps
`default_nettype none
module flash_write_protect_decoder_tb_top;
  logic        core_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmd_valid;
  logic [2:0]  cmd_op;
  logic [23:0] cmd_addr;
  logic [8:0]  cmd_len;
  logic        cmd_done;
  logic        cmd_refused;
  logic [12:0] cmd_page;
  logic [3:0]  cmd_pib;
  logic        host_tmo;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic        err;
  logic        x_ref;
  int          n_mismatch;
  int          cmp_count;
  int          c;
  int          o;
  int          k;
  logic [20:0] addrs [10] = '{21'h000000, 21'h007A00, 21'h008000, 21'h00F000,
                              21'h010000, 21'h0FFF00, 21'h100000, 21'h1EFF00,
                              21'h1FF000, 21'h1FFF00};

  fwpd_protect_decoder i_dut (
    .CORE_CLK(core_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
    .CMD_LEN(cmd_len), .CMD_DONE(cmd_done), .CMD_REFUSED(cmd_refused),
    .CMD_PAGE(cmd_page), .CMD_PAGE_IN_BLOCK(cmd_pib));

  fwpd_host_model i_host (
    .clk(core_clk), .done(cmd_done), .refused(cmd_refused), .valid(cmd_valid),
    .op(cmd_op), .addr(cmd_addr), .len(cmd_len), .tmo(host_tmo));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic x, input logic g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", n, x, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // reference decision: span overlap against the protected range
  function automatic logic exp_ref(logic [31:0] f, logic [2:0] op, logic [20:0] a,
                                   logic [8:0] l);
    logic [2:0]  e;
    logic [20:0] sz;
    logic [20:0] lo;
    logic [20:0] hi;
    logic [20:0] m;
    logic        none;
    e = f[4:2];
    if (op > 3'h5 || (op == 3'h0 && (l == 9'h000 || l > 9'h100))) return 1'b1;
    sz = f[6] ? (21'h001000 << ((e > 3'h4 ? 3'h4 : e) - 3'h1))
              : (21'h010000 << (e - 3'h1));
    lo = f[5] ? 21'h000000 : 21'h1FFFFF - sz + 21'h000001;
    hi = f[5] ? sz - 21'h000001 : 21'h1FFFFF;
    none = (e == 3'h0);
    if (e > 3'h5 || (f[14] && e == 3'h0)) begin
      lo = 21'h000000;
      hi = 21'h1FFFFF;
    end else if (f[14]) begin
      lo = f[5] ? sz : 21'h000000;
      hi = f[5] ? 21'h1FFFFF : 21'h1FFFFF - sz;
      if (f[6] && op == 3'h3) begin
        lo = f[5] ? 21'h008000 : 21'h000000;
        hi = f[5] ? 21'h1FFFFF : 21'h1F7FFF;
      end
      if (f[6] && op == 3'h4) begin
        lo = f[5] ? 21'h010000 : 21'h000000;
        hi = f[5] ? 21'h1FFFFF : 21'h1EFFFF;
      end
    end
    if (f[14]) none = (e > 3'h5);
    case (op)
      3'h0, 3'h1: m = 21'h0000FF;
      3'h2:       m = 21'h000FFF;
      3'h3:       m = 21'h007FFF;
      3'h4:       m = 21'h00FFFF;
      default:    m = 21'h1FFFFF;
    endcase
    return !none && ((a & ~m) <= hi) && ((a | m) >= lo);
  endfunction

  // one command with its decision and page outputs compared
  task automatic cmd(input logic [2:0] op, input logic [20:0] a, input logic [8:0] l,
                     input logic x);
    logic r;
    i_host.send(op, {3'h5, a}, l, r);
    if (host_tmo === 1'b1) begin
      n_mismatch++;
      final_report();
    end
    chk_bit("refused", x, r);
    chk_word("page", {19'h0, a[20:8]}, {19'h0, cmd_page});
    chk_word("page in block", {28'h0, a[11:8]}, {28'h0, cmd_pib});
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, fwpd_pkg::REG_CFG, 32'h0, 4'h0, rd, err);
    chk_word("cfg reset", 32'h00000000, rd);
    apb(1'b0, fwpd_pkg::REG_LOCK_LO, 32'h0, 4'h0, rd, err);
    chk_word("lock reset", 32'hFFFFFFFF, rd);
    apb(1'b1, fwpd_pkg::REG_CFG, 32'hFFFFFFFF, 4'h1, rd, err);
    apb(1'b0, fwpd_pkg::REG_CFG, 32'h0, 4'h0, rd, err);
    chk_word("cfg lane", 32'h0000007C, rd);
    apb(1'b0, 12'h018, 32'h0, 4'h0, rd, err);
    chk_bit("unmapped error", 1'b1, err);
    chk_word("unmapped data", 32'h00000000, rd);
    // program length boundaries and the top address under an empty range
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h00000000, 4'hF, rd, err);
    cmd(3'h0, 21'h000000, 9'h000, 1'b1);
    cmd(3'h0, 21'h000000, 9'h101, 1'b1);
    cmd(3'h0, 21'h1FFFFF, 9'h001, 1'b0);
    // every range setting combination, scheme bit clear, against every op and edge address
    for (c = 0; c < 64; c++) begin
      cfg = 32'h0;
      cfg[4:2] = c[2:0];
      cfg[5] = c[3];
      cfg[6] = c[4];
      cfg[14] = c[5];
      apb(1'b1, fwpd_pkg::REG_CFG, cfg, 4'hF, rd, err);
      for (o = 0; o < 8; o++) begin
        for (k = 0; k < 10; k++) begin
          x_ref = exp_ref(cfg, o[2:0], addrs[k], 9'h100);
          cmd(o[2:0], addrs[k], 9'h100, x_ref);
        end
      end
    end
    // fixed points on the range edges, independent of the reference function
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h0000000C, 4'hF, rd, err);
    cmd(3'h0, 21'h1BFF00, 9'h001, 1'b0);
    cmd(3'h0, 21'h1C0000, 9'h001, 1'b1);
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h00000030, 4'hF, rd, err);
    cmd(3'h0, 21'h07FF00, 9'h001, 1'b1);
    cmd(3'h0, 21'h080000, 9'h001, 1'b0);
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h00000054, 4'hF, rd, err);
    cmd(3'h0, 21'h1F7F00, 9'h001, 1'b0);
    cmd(3'h0, 21'h1F8000, 9'h001, 1'b1);
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h00004064, 4'hF, rd, err);
    cmd(3'h0, 21'h000F00, 9'h001, 1'b0);
    cmd(3'h1, 21'h001000, 9'h001, 1'b1);
    cmd(3'h3, 21'h007000, 9'h001, 1'b0);
    cmd(3'h3, 21'h00F000, 9'h001, 1'b1);
    cmd(3'h4, 21'h00F000, 9'h001, 1'b0);
    // lock scheme overrides a full-array range setting
    apb(1'b1, fwpd_pkg::REG_CFG, 32'h0004001C, 4'hF, rd, err);
    cmd(3'h0, 21'h100000, 9'h010, 1'b1);
    apb(1'b1, fwpd_pkg::REG_LOCK_LO, 32'h00010000, 4'hF, rd, err);
    apb(1'b1, fwpd_pkg::REG_LOCK_HI, 32'h00000001, 4'hF, rd, err);
    cmd(3'h5, 21'h000000, 9'h010, 1'b1);
    cmd(3'h0, 21'h100000, 9'h010, 1'b0);
    cmd(3'h0, 21'h1F0000, 9'h010, 1'b1);
    cmd(3'h0, 21'h1F1000, 9'h010, 1'b0);
    cmd(3'h4, 21'h1F8000, 9'h010, 1'b1);
    cmd(3'h2, 21'h1FF000, 9'h010, 1'b0);
    cmd(3'h0, 21'h01FF00, 9'h010, 1'b1);
    cmd(3'h1, 21'h020000, 9'h010, 1'b0);
    // refusal count has saturated by now; last command used the lock scheme
    apb(1'b0, fwpd_pkg::REG_STATUS, 32'h0, 4'h0, rd, err);
    chk_word("status", 32'h0000FF04, rd);
    apb(1'b0, fwpd_pkg::REG_RANGE_HI, 32'h0, 4'h0, rd, err);
    chk_word("range hi", 32'h001FFFFF, rd);
    final_report();
  end
endmodule
`default_nettype wire

/* File: sim/fwpd_host_model.sv */
// fwpd_host_model: command source standing in for the spi host controller
// assumes the decoder answers with a done pulse one cycle after a request
`timescale 1ns/1ps
`default_nettype none
module fwpd_host_model (
  input  wire logic        clk,
  input  wire logic        done,
  input  wire logic        refused,
  output logic             valid,
  output logic [2:0]       op,
  output logic [23:0]      addr,
  output logic [8:0]       len,
  output logic             tmo
);
  initial begin
    valid = 1'b0;
    op    = 3'h0;
    addr  = 24'h000000;
    len   = 9'h000;
    tmo   = 1'b0;
  end

  // one request; fields inverted once released so stale values never look valid
  task automatic send(input logic [2:0] o, input logic [23:0] a,
                      input logic [8:0] l, output logic r);
    int i;
    @(posedge clk);
    valid <= 1'b1;
    op    <= o;
    addr  <= a;
    len   <= l;
    @(posedge clk);
    valid <= 1'b0;
    op    <= ~o;
    addr  <= ~a;
    len   <= ~l;
    r = 1'bx;
    tmo = 1'b1;
    // bounded wait; a missing answer is left for the bench to judge
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (done === 1'b1) begin
        r = refused;
        tmo = 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: src/fwpd_lock_map.sv */
// fwpd_lock_map: per-block lock bits checked against a target span
// assumes edge 64 KB blocks lock per 4 KB and inner ones per 64 KB
`timescale 1ns/1ps
`default_nettype none
module fwpd_lock_map (
  input  wire logic [61:0] locks,
  input  wire logic [20:0] span_lo,
  input  wire logic [20:0] span_hi,
  output logic             hit
);

  localparam int EDGE = fwpd_pkg::LOCK_EDGE;
  localparam int S4K  = int'(fwpd_pkg::SIZE_4K);
  localparam int S64K = int'(fwpd_pkg::SIZE_64K);

  logic [61:0] hit_vec;

  // one comparator pair per lock bit; bits 0-15 bottom, 16-31 top, rest inner
  for (genvar i = 0; i < fwpd_pkg::LOCK_BITS; i++) begin : g_lock
    localparam int SPAN_I = (i < 2 * EDGE) ? S4K : S64K;
    localparam int LO_I   = (i < EDGE) ? i * S4K :
                            (i < 2 * EDGE) ? int'(fwpd_pkg::TOP_EDGE_BASE) + (i - EDGE) * S4K :
                            (i - 2 * EDGE + 1) * S64K;
    localparam logic [20:0] LO = 21'(LO_I);
    localparam logic [20:0] HI = 21'(LO_I + SPAN_I - 1);
    assign hit_vec[i] = locks[i] && span_lo <= HI && span_hi >= LO;
  end

  assign hit = |hit_vec;

endmodule
`default_nettype wire

/* File: src/fwpd_pkg.sv */
// fwpd_pkg: constants and types shared by the flash write-protect decoder
// assumes a 2 MB array addressed by 21 bits; upper address bits are ignored
`default_nettype none
package fwpd_pkg;

  // array geometry
  localparam int          ARRAY_AW      = 21;
  localparam logic [20:0] ARRAY_TOP     = 21'h1FFFFF;
  localparam logic [20:0] SIZE_PAGE     = 21'h000100;
  localparam logic [20:0] SIZE_4K       = 21'h001000;
  localparam logic [20:0] SIZE_32K      = 21'h008000;
  localparam logic [20:0] SIZE_64K      = 21'h010000;
  localparam logic [20:0] TOP_EDGE_BASE = 21'h1F0000;
  localparam int          PAGE_LSB      = 8;
  localparam int          PAGE_IN_MSB   = 11;

  // widened bounds for large erases under complement at 4 KB granule
  localparam logic [20:0] WIDE32_TOP_HI = 21'h1F7FFF;
  localparam logic [20:0] WIDE32_BOT_LO = 21'h008000;
  localparam logic [20:0] WIDE64_TOP_HI = 21'h1EFFFF;
  localparam logic [20:0] WIDE64_BOT_LO = 21'h010000;

  // extent field codes
  localparam logic [2:0] EXT_NONE     = 3'h0;
  localparam logic [2:0] EXT_GRAN_CAP = 3'h4;
  localparam logic [2:0] EXT_PART_MAX = 3'h5;

  // per-block lock geometry
  localparam int LOCK_BITS  = 62;
  localparam int LOCK_EDGE  = 16;

  // register map, byte addresses
  localparam logic [11:0] REG_CFG      = 12'h000;
  localparam logic [11:0] REG_LOCK_LO  = 12'h004;
  localparam logic [11:0] REG_LOCK_HI  = 12'h008;
  localparam logic [11:0] REG_RANGE_LO = 12'h00C;
  localparam logic [11:0] REG_RANGE_HI = 12'h010;
  localparam logic [11:0] REG_STATUS   = 12'h014;

  // config layout: status register 1 in [7:0], 2 in [15:8], 3 in [23:16]
  localparam int          CFG_EXT_LSB     = 2;
  localparam int          CFG_EXT_MSB     = 4;
  localparam int          CFG_BOTTOM_BIT  = 5;
  localparam int          CFG_GRANULE_BIT = 6;
  localparam int          CFG_INVERT_BIT  = 14;
  localparam int          CFG_SCHEME_BIT  = 18;
  localparam logic [31:0] CFG_MASK        = 32'h0004407C;
  localparam logic [31:0] CFG_RESET       = 32'h00000000;
  localparam logic [61:0] LOCK_RESET      = {62{1'b1}};
  localparam logic [8:0]  PROG_LEN_MAX    = 9'h100;

  // status layout
  localparam int STAT_REFUSED_BIT = 0;
  localparam int STAT_NONE_BIT    = 1;
  localparam int STAT_SCHEME_BIT  = 2;
  localparam int STAT_CNT_LSB     = 8;

  typedef enum logic [2:0] {
    OP_PROGRAM    = 3'h0,
    OP_ERASE_PAGE = 3'h1,
    OP_ERASE_4K   = 3'h2,
    OP_ERASE_32K  = 3'h3,
    OP_ERASE_64K  = 3'h4,
    OP_ERASE_CHIP = 3'h5
  } fwpd_op_t;

endpackage
`default_nettype wire

/* File: src/fwpd_protect_decoder.sv */
// fwpd_protect_decoder: decides whether a program or erase may proceed
// assumes an APB master and a command source, both on CORE_CLK
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - each 4 KB block holds sixteen 256-byte pages; program spans one page
// - protection resolves down to a single 4 KB block
// - lock all blocks at once or lock chosen blocks singly
// - scheme bit clear: protection comes from complement, granule, direction, extent
// - complement bit inverts the protected map
// - granule bit picks 4 KB or 64 KB extent units
// - direction bit picks growth from bottom or from top
// - extent field selects all, none or a part
// - refuse program or erase that targets protected range
// - top-down 64 KB: none, top 64K..1M, then whole array
// - bottom-up 64 KB: none, low 64K..1M, then whole array
// - 4 KB granule: none, 4..32 KB, 32 KB again, then all
// - complement: extent 0 all, 6 and 7 none, else outside region
// - complement 4 KB: 32 KB erase checked against widened region
// - complement 4 KB: 64 KB erase checked against widened region
// - anything outside the selected range is writable
// - scheme bit set: per-block lock bits replace the range decode
module fwpd_protect_decoder #(
  parameter int ADDR_W  = 24,
  parameter int PADDR_W = 12
) (
  input  wire logic               CORE_CLK,
  input  wire logic               RESET,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  input  wire logic [3:0]         PSTRB,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               CMD_VALID,
  input  wire logic [2:0]         CMD_OP,
  input  wire logic [ADDR_W-1:0]  CMD_ADDR,
  input  wire logic [8:0]         CMD_LEN,
  output logic                    CMD_DONE,
  output logic                    CMD_REFUSED,
  output logic      [12:0]        CMD_PAGE,
  output logic      [3:0]         CMD_PAGE_IN_BLOCK
);

  logic [31:0] cfg_q;
  logic [61:0] lock_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic        wr_en;
  logic        setup;
  logic [11:0] reg_addr;
  logic        addr_hit;

  logic [2:0]  protect_extent_field;
  logic        protect_from_bottom;
  logic        protect_granule_size;
  logic        protect_complement;
  logic        protect_scheme_select;

  logic [20:0] addr;
  logic [20:0] span_mask;
  logic [20:0] span_lo;
  logic [20:0] span_hi;
  logic [20:0] rng_lo;
  logic [20:0] rng_hi;
  logic        rng_none;
  logic        lock_hit;
  logic        std_hit;
  logic        legal;
  logic        refuse_d;

  logic        done_q;
  logic        refused_q;
  logic [12:0] page_q;
  logic [3:0]  page_in_q;
  logic [20:0] last_lo_q;
  logic [20:0] last_hi_q;
  logic        last_none_q;
  logic        last_scheme_q;
  logic [7:0]  refuse_cnt_q;

  // byte-lane merge for APB writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = wdata[b*8 +: 8];
    end
    return res;
  endfunction

  // field views of the settings word
  assign protect_extent_field  = cfg_q[fwpd_pkg::CFG_EXT_MSB:fwpd_pkg::CFG_EXT_LSB];
  assign protect_from_bottom   = cfg_q[fwpd_pkg::CFG_BOTTOM_BIT];
  assign protect_granule_size  = cfg_q[fwpd_pkg::CFG_GRANULE_BIT];
  assign protect_complement    = cfg_q[fwpd_pkg::CFG_INVERT_BIT];
  assign protect_scheme_select = cfg_q[fwpd_pkg::CFG_SCHEME_BIT];

  // apb strobes; zero wait states so pready never stalls
  assign reg_addr = 12'(PADDR);
  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign setup    = PSEL && !PENABLE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !addr_hit;
  assign PRDATA   = prdata_q;

  // settings word; undefined bits forced low so they read as zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cfg_q <= fwpd_pkg::CFG_RESET;
    end else if (wr_en && reg_addr == fwpd_pkg::REG_CFG) begin
      cfg_q <= lane_merge(cfg_q, PWDATA, PSTRB) & fwpd_pkg::CFG_MASK;
    end
  end

  // lock bits come up all set, so every block starts protected
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      lock_q <= fwpd_pkg::LOCK_RESET;
    end else if (wr_en && reg_addr == fwpd_pkg::REG_LOCK_LO) begin
      lock_q[31:0] <= lane_merge(lock_q[31:0], PWDATA, PSTRB);
    end else if (wr_en && reg_addr == fwpd_pkg::REG_LOCK_HI) begin
      lock_q[61:32] <= 30'(lane_merge({2'b00, lock_q[61:32]}, PWDATA, PSTRB));
    end
  end

  // read decode; unmapped addresses read zero and flag an error
  always_comb begin
    rd_d     = '0;
    addr_hit = 1'b1;
    unique case (reg_addr)
      fwpd_pkg::REG_CFG:      rd_d = cfg_q;
      fwpd_pkg::REG_LOCK_LO:  rd_d = lock_q[31:0];
      fwpd_pkg::REG_LOCK_HI:  rd_d = {2'b00, lock_q[61:32]};
      fwpd_pkg::REG_RANGE_LO: rd_d = {11'h000, last_lo_q};
      fwpd_pkg::REG_RANGE_HI: rd_d = {11'h000, last_hi_q};
      fwpd_pkg::REG_STATUS: begin
        rd_d[fwpd_pkg::STAT_REFUSED_BIT]             = refused_q;
        rd_d[fwpd_pkg::STAT_NONE_BIT]                = last_none_q;
        rd_d[fwpd_pkg::STAT_SCHEME_BIT]              = last_scheme_q;
        rd_d[fwpd_pkg::STAT_CNT_LSB +: 8]            = refuse_cnt_q;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // read data captured in the setup phase, held through the access phase
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prdata_q <= '0;
    end else if (setup && !PWRITE) begin
      prdata_q <= rd_d;
    end
  end

  // only the low 21 bits address the 2 MB array
  assign addr = CMD_ADDR[fwpd_pkg::ARRAY_AW-1:0];

  // span touched by the operation; a program wraps inside its page
  always_comb begin
    unique case (CMD_OP)
      fwpd_pkg::OP_PROGRAM,
      fwpd_pkg::OP_ERASE_PAGE: span_mask = fwpd_pkg::SIZE_PAGE - 21'h1;
      fwpd_pkg::OP_ERASE_4K:   span_mask = fwpd_pkg::SIZE_4K - 21'h1;
      fwpd_pkg::OP_ERASE_32K:  span_mask = fwpd_pkg::SIZE_32K - 21'h1;
      fwpd_pkg::OP_ERASE_64K:  span_mask = fwpd_pkg::SIZE_64K - 21'h1;
      default:                 span_mask = fwpd_pkg::ARRAY_TOP;
    endcase
  end

  assign span_lo = addr & ~span_mask;
  assign span_hi = span_lo | span_mask;

  // command sanity: known opcode, program length 1..256 bytes
  assign legal = (CMD_OP <= fwpd_pkg::OP_ERASE_CHIP) &&
                 (CMD_OP != fwpd_pkg::OP_PROGRAM ||
                  (CMD_LEN != 9'h000 && CMD_LEN <= fwpd_pkg::PROG_LEN_MAX));

  fwpd_range_dec u_range (
    .ext         (protect_extent_field),
    .from_bottom (protect_from_bottom),
    .granule_4k  (protect_granule_size),
    .invert      (protect_complement),
    .op          (CMD_OP),
    .lo          (rng_lo),
    .hi          (rng_hi),
    .none        (rng_none)
  );

  fwpd_lock_map u_lock (
    .locks   (lock_q),
    .span_lo (span_lo),
    .span_hi (span_hi),
    .hit     (lock_hit)
  );

  // any overlap with the protected range refuses; the rest is writable
  assign std_hit  = !rng_none && span_lo <= rng_hi && span_hi >= rng_lo;
  assign refuse_d = !legal || (protect_scheme_select ? lock_hit : std_hit);

  // decision registered one cycle after the command is taken
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= CMD_VALID;
      if (CMD_VALID) refused_q <= refuse_d;
    end
  end

  // page number of the target and its page position within its 4 KB block
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      page_q    <= '0;
      page_in_q <= '0;
    end else if (CMD_VALID) begin
      page_q    <= addr[fwpd_pkg::ARRAY_AW-1:fwpd_pkg::PAGE_LSB];
      page_in_q <= addr[fwpd_pkg::PAGE_IN_MSB:fwpd_pkg::PAGE_LSB];
    end
  end

  // range that judged the last command, for software to inspect
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      last_lo_q     <= '0;
      last_hi_q     <= '0;
      last_none_q   <= 1'b0;
      last_scheme_q <= 1'b0;
    end else if (CMD_VALID) begin
      last_lo_q     <= rng_lo;
      last_hi_q     <= rng_hi;
      last_none_q   <= rng_none;
      last_scheme_q <= protect_scheme_select;
    end
  end

  // saturating count so a flood of refusals cannot wrap back to zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      refuse_cnt_q <= '0;
    end else if (CMD_VALID && refuse_d && refuse_cnt_q != 8'hFF) begin
      refuse_cnt_q <= refuse_cnt_q + 8'h01;
    end
  end

  assign CMD_DONE          = done_q;
  assign CMD_REFUSED       = refused_q;
  assign CMD_PAGE          = page_q;
  assign CMD_PAGE_IN_BLOCK = page_in_q;

  // checks on the decision path
  logic std_mode;
  logic part_ext;
  assign std_mode = CMD_VALID && legal && !protect_scheme_select;
  assign part_ext = protect_extent_field != fwpd_pkg::EXT_NONE &&
                    protect_extent_field <= fwpd_pkg::EXT_PART_MAX;

  property p_refuse;
    @(posedge CORE_CLK) disable iff (RESET)
      CMD_VALID && refuse_d |=> CMD_DONE && CMD_REFUSED;
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected target not refused");

  property p_free;
    @(posedge CORE_CLK) disable iff (RESET)
      CMD_VALID && !refuse_d |=> CMD_DONE && !CMD_REFUSED;
  endproperty
  a_free: assert property (p_free) else $error("unprotected target refused");

  property p_none;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && !protect_complement && protect_extent_field == fwpd_pkg::EXT_NONE
      |=> !CMD_REFUSED;
  endproperty
  a_none: assert property (p_none) else $error("extent zero protected something");

  property p_all;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && !protect_complement && protect_extent_field > fwpd_pkg::EXT_PART_MAX
      |=> CMD_REFUSED;
  endproperty
  a_all: assert property (p_all) else $error("whole-array extent let a write through");

  property p_cmp_all;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && protect_complement && protect_extent_field == fwpd_pkg::EXT_NONE
      |=> CMD_REFUSED;
  endproperty
  a_cmp_all: assert property (p_cmp_all) else $error("complement extent zero left a gap");

  property p_cmp_flip;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && protect_complement && !protect_granule_size && part_ext &&
      CMD_OP == fwpd_pkg::OP_PROGRAM && !protect_from_bottom &&
      span_lo > fwpd_pkg::ARRAY_TOP - (fwpd_pkg::SIZE_64K << (protect_extent_field - 3'h1))
      |=> !CMD_REFUSED;
  endproperty
  a_cmp_flip: assert property (p_cmp_flip) else $error("complement kept top region");

  property p_wide32;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && protect_complement && protect_granule_size && part_ext &&
      !protect_from_bottom && CMD_OP == fwpd_pkg::OP_ERASE_32K &&
      span_lo > fwpd_pkg::WIDE32_TOP_HI |=> !CMD_REFUSED;
  endproperty
  a_wide32: assert property (p_wide32) else $error("32 KB erase not widened");

  property p_wide64;
    @(posedge CORE_CLK) disable iff (RESET)
      std_mode && protect_complement && protect_granule_size && part_ext &&
      protect_from_bottom && CMD_OP == fwpd_pkg::OP_ERASE_64K &&
      span_hi < fwpd_pkg::WIDE64_BOT_LO |=> !CMD_REFUSED;
  endproperty
  a_wide64: assert property (p_wide64) else $error("64 KB erase not widened");

  property p_lock;
    @(posedge CORE_CLK) disable iff (RESET)
      CMD_VALID && legal && protect_scheme_select |=> CMD_REFUSED == $past(lock_hit);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bits not applied");

  property p_page;
    @(posedge CORE_CLK) disable iff (RESET)
      CMD_VALID |=> CMD_PAGE_IN_BLOCK == CMD_PAGE[3:0] && CMD_DONE;
  endproperty
  a_page: assert property (p_page) else $error("page index mismatch");

  c_lock_refuse: cover property (@(posedge CORE_CLK) disable iff (RESET)
    CMD_VALID && protect_scheme_select && lock_hit ##1 CMD_REFUSED);
  c_wide_accept: cover property (@(posedge CORE_CLK) disable iff (RESET)
    std_mode && protect_complement && CMD_OP == fwpd_pkg::OP_ERASE_32K ##1 !CMD_REFUSED);
  c_prog_ok: cover property (@(posedge CORE_CLK) disable iff (RESET)
    std_mode && CMD_OP == fwpd_pkg::OP_PROGRAM ##1 !CMD_REFUSED);

endmodule
`default_nettype wire

/* File: src/fwpd_range_dec.sv */
// fwpd_range_dec: turns the standard protection settings into one range
// assumes settings are stable for the cycle; purely combinational
`timescale 1ns/1ps
`default_nettype none
module fwpd_range_dec (
  input  wire logic [2:0]  ext,
  input  wire logic        from_bottom,
  input  wire logic        granule_4k,
  input  wire logic        invert,
  input  wire logic [2:0]  op,
  output logic      [20:0] lo,
  output logic      [20:0] hi,
  output logic             none
);

  logic [2:0]  ext_cap;
  logic [2:0]  shamt;
  logic [20:0] sz;

  // region size; the 4 KB granule stops growing at 32 KB
  always_comb begin
    ext_cap = (granule_4k && ext > fwpd_pkg::EXT_GRAN_CAP) ? fwpd_pkg::EXT_GRAN_CAP : ext;
    shamt   = ext_cap - 3'h1;
    sz      = granule_4k ? (fwpd_pkg::SIZE_4K << shamt) : (fwpd_pkg::SIZE_64K << shamt);
  end

  // range select, with complement and the widened large-erase bounds
  always_comb begin
    none = 1'b0;
    lo   = '0;
    hi   = fwpd_pkg::ARRAY_TOP;
    if (ext == fwpd_pkg::EXT_NONE) begin
      none = !invert;
    end else if (ext > fwpd_pkg::EXT_PART_MAX) begin
      none = invert;
    end else if (!invert) begin
      if (from_bottom) hi = sz - 21'h1;
      else lo = fwpd_pkg::ARRAY_TOP - sz + 21'h1;
    end else begin
      if (from_bottom) lo = sz;
      else hi = fwpd_pkg::ARRAY_TOP - sz;
      if (granule_4k && op == fwpd_pkg::OP_ERASE_32K) begin
        if (from_bottom) lo = fwpd_pkg::WIDE32_BOT_LO;
        else hi = fwpd_pkg::WIDE32_TOP_HI;
      end
      if (granule_4k && op == fwpd_pkg::OP_ERASE_64K) begin
        if (from_bottom) lo = fwpd_pkg::WIDE64_BOT_LO;
        else hi = fwpd_pkg::WIDE64_TOP_HI;
      end
    end
  end

endmodule
`default_nettype wire
